// [hw/cfg_pkg.sv]
package cfg_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    CFG_LOADING, CFG_RELEASED, CFG_USER
  } cfg_state_e;

  // Each serial input comes with a flag saying whether anyone drives it
  typedef struct packed {
    logic tms;
    logic tms_driven;
    logic tdi;
    logic tdi_driven;
  } tap_pins_s;

  typedef struct packed {
    logic user_mode;
    logic loading;
  } cfg_status_s;

endpackage

// [hw/cfg_tap_consts.svh]
`ifndef CFG_TAP_CONSTS_SVH
`define CFG_TAP_CONSTS_SVH

// ----------------------------------------
// Core clock and reconfiguration timing
// ----------------------------------------
`define CLOCK_NS 100
`define RECONF_MIN_NS 320
`define RECONF_MIN_CYCLES ((`RECONF_MIN_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define RECONF_CNT_W 4
`define LOAD_CYCLES 64
`define LOAD_CNT_W 7

// ----------------------------------------
// Test access port registers
// ----------------------------------------
`define IR_W 4
`define IR_CAPTURE 4'h1
`define IR_IDCODE 4'h3
`define IR_STATUS 4'h5
`define IR_BYPASS 4'hf
`define IDCODE_W 32
`define STATUS_W 8

`endif

// [hw/config_test_port.sv]
`timescale 1ns/1ps
`include "cfg_tap_consts.svh"
module config_test_port #(
  parameter logic [`IDCODE_W-1:0] IDCODE = 32'h0a5a_5001 // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_enable,
  input wire logic test_clock,
  input wire cfg_pkg::tap_pins_s tap_in,
  input wire logic reconfig_n,
  input wire logic config_done_pin,
  output logic config_done_out,
  output logic config_done_oe,
  output logic user_mode,
  output logic config_loading,
  output logic tdo_out,
  output logic tdo_oe
);
  import cfg_pkg::*;

  // ----------------------------------------
  // Core domain: pin synchronisers
  // ----------------------------------------
  logic reconf_meta, reconf_sync, reconf_prev;
  logic done_meta, done_sync;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reconf_meta <= 1'b1;
      reconf_sync <= 1'b1;
      reconf_prev <= 1'b1;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
    end else if (clock_enable) begin
      reconf_meta <= reconfig_n;
      reconf_sync <= reconf_meta;
      reconf_prev <= reconf_sync;
      done_meta <= config_done_pin;
      done_sync <= done_meta;
    end
  end

  // ----------------------------------------
  // Core domain: reconfiguration and loading
  // ----------------------------------------
  cfg_state_e state, next_state;
  logic [`RECONF_CNT_W-1:0] low_count, next_low_count;
  logic [`LOAD_CNT_W-1:0] load_count, next_load_count;
  logic next_user_mode;
  logic reconf_start;

  // Short glitches on the trigger are dropped; only a full-width pulse counts
  assign reconf_start = reconf_sync && !reconf_prev
    && (low_count >= `RECONF_CNT_W'(`RECONF_MIN_CYCLES));

  always_comb begin
    next_state = state;
    next_load_count = load_count;
    next_low_count = low_count;
    if (!reconf_sync) begin
      if (low_count < `RECONF_CNT_W'(`RECONF_MIN_CYCLES)) begin
        next_low_count = low_count + `RECONF_CNT_W'(1);
      end
    end else begin
      next_low_count = '0;
    end
    unique case (state)
      CFG_LOADING: begin
        next_load_count = load_count + `LOAD_CNT_W'(1);
        if (load_count == `LOAD_CNT_W'(`LOAD_CYCLES - 1)) begin
          next_state = CFG_RELEASED;
        end
      end
      CFG_RELEASED: begin
        // An outside party holding the flag low parks us here
        if (done_sync) begin
          next_state = CFG_USER;
        end
      end
      CFG_USER: begin
        next_state = CFG_USER;
      end
    endcase
    // Only the loader restarts and user mode drops; the test port is not reset from here
    if (reconf_start) begin
      next_state = CFG_LOADING;
      next_load_count = '0;
    end
    next_user_mode = (next_state == CFG_USER);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= CFG_LOADING;
      load_count <= '0;
      low_count <= '0;
      user_mode <= 1'b0;
      config_done_oe <= 1'b1;
    end else if (clock_enable) begin
      state <= next_state;
      load_count <= next_load_count;
      low_count <= next_low_count;
      user_mode <= next_user_mode;
      config_done_oe <= (next_state == CFG_LOADING);
    end
  end

  // Open drain: only ever pulls low
  assign config_done_out = 1'b0;
  assign config_loading = config_done_oe;

  // ----------------------------------------
  // Test clock domain: reset and status crossing
  // ----------------------------------------
  logic trst_meta, tap_rst_n;
  cfg_status_s status_meta, status_sync;

  always_ff @(posedge test_clock or negedge rst_n) begin
    if (!rst_n) begin
      trst_meta <= 1'b0;
      tap_rst_n <= 1'b0;
    end else begin
      trst_meta <= 1'b1;
      tap_rst_n <= trst_meta;
    end
  end

  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      status_meta <= '0;
      status_sync <= '0;
    end else begin
      status_meta <= '{user_mode: user_mode, loading: config_done_oe};
      status_sync <= status_meta;
    end
  end

  // ----------------------------------------
  // Test clock domain: controller
  // ----------------------------------------
  tap_state_e tap_state, next_tap_state;
  logic tms_eff, tdi_eff;

  // Weak pull-up seen as a one whenever nobody drives the pin
  assign tms_eff = tap_in.tms_driven ? tap_in.tms : 1'b1;
  assign tdi_eff = tap_in.tdi_driven ? tap_in.tdi : 1'b1;

  always_comb begin
    next_tap_state = tap_state;
    unique case (tap_state)
      TEST_LOGIC_RESET: next_tap_state = tms_eff ? TEST_LOGIC_RESET : RUN_IDLE;
      RUN_IDLE: next_tap_state = tms_eff ? SELECT_DR : RUN_IDLE;
      SELECT_DR: next_tap_state = tms_eff ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: next_tap_state = tms_eff ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: next_tap_state = tms_eff ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: next_tap_state = tms_eff ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: next_tap_state = tms_eff ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: next_tap_state = tms_eff ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: next_tap_state = tms_eff ? SELECT_DR : RUN_IDLE;
      SELECT_IR: next_tap_state = tms_eff ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: next_tap_state = tms_eff ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: next_tap_state = tms_eff ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: next_tap_state = tms_eff ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: next_tap_state = tms_eff ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: next_tap_state = tms_eff ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: next_tap_state = tms_eff ? SELECT_DR : RUN_IDLE;
    endcase
  end

  // ----------------------------------------
  // Test clock domain: instruction and data paths
  // ----------------------------------------
  logic [`IR_W-1:0] instr, next_instr;
  logic [`IR_W-1:0] ir_q;
  logic [`IDCODE_W-1:0] id_q;
  logic [`STATUS_W-1:0] st_q;
  logic ir_so, id_so, st_so;
  logic bypass, next_bypass;
  logic sel_id, sel_st, sel_by;
  logic shift_ir, shift_dr, sel_out;

  assign shift_ir = (tap_state == SHIFT_IR);
  assign shift_dr = (tap_state == SHIFT_DR);
  assign sel_id = (instr == `IR_IDCODE);
  assign sel_st = (instr == `IR_STATUS);
  assign sel_by = !sel_id && !sel_st;

  // Only the data chain picked by the current instruction moves; the instruction chain moves in every IR scan
  scan_chain #(.WIDTH(`IR_W)) ir_chain (
    .tck(test_clock),
    .rst_n(tap_rst_n),
    .reset_value(`IR_CAPTURE),
    .capture(tap_state == CAPTURE_IR),
    .shift(shift_ir),
    .capture_value(`IR_CAPTURE),
    .si(tdi_eff),
    .so(ir_so),
    .q(ir_q)
  );

  scan_chain #(.WIDTH(`IDCODE_W)) id_chain (
    .tck(test_clock),
    .rst_n(tap_rst_n),
    .reset_value(IDCODE),
    .capture(tap_state == CAPTURE_DR && sel_id),
    .shift(shift_dr && sel_id),
    .capture_value(IDCODE),
    .si(tdi_eff),
    .so(id_so),
    .q(id_q)
  );

  scan_chain #(.WIDTH(`STATUS_W)) st_chain (
    .tck(test_clock),
    .rst_n(tap_rst_n),
    .reset_value('0),
    .capture(tap_state == CAPTURE_DR && sel_st),
    .shift(shift_dr && sel_st),
    .capture_value({{(`STATUS_W - 2){1'b0}}, status_sync}),
    .si(tdi_eff),
    .so(st_so),
    .q(st_q)
  );

  always_comb begin
    next_instr = instr;
    next_bypass = bypass;
    if (tap_state == TEST_LOGIC_RESET) begin
      next_instr = `IR_IDCODE;
    end else if (tap_state == UPDATE_IR) begin
      next_instr = ir_q;
    end
    if (tap_state == CAPTURE_DR && sel_by) begin
      next_bypass = 1'b0;
    end else if (shift_dr && sel_by) begin
      next_bypass = tdi_eff;
    end
  end

  // Inputs are sampled only on the rising edge
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tap_state <= TEST_LOGIC_RESET;
      instr <= `IR_IDCODE;
      bypass <= 1'b0;
    end else begin
      tap_state <= next_tap_state;
      instr <= next_instr;
      bypass <= next_bypass;
    end
  end

  // Serial output follows the chain that is actually shifting
  always_comb begin
    if (shift_ir) begin
      sel_out = ir_so;
    end else if (sel_id) begin
      sel_out = id_so;
    end else if (sel_st) begin
      sel_out = st_so;
    end else begin
      sel_out = bypass;
    end
  end

  // Falling-edge launch gives the host a full half period of hold; the pad drives only while shifting.
  // The pin buffer is hard-wired to this port with no user mux.
  always_ff @(negedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_out <= sel_out;
      tdo_oe <= shift_ir || shift_dr;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // A synced low of exactly three cycles, one short of the minimum
  sequence short_pulse_s;
    reconf_sync ##1 !reconf_sync [*3] ##1 reconf_sync;
  endsequence

  done_release_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clock_enable && $fell(config_done_oe)) |-> $past(load_count) == `LOAD_CNT_W'(`LOAD_CYCLES - 1))
    else $error("done flag released before loading finished");
  held_low_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state != CFG_USER && !done_sync) |=> !user_mode)
    else $error("user mode entered while done flag held low");
  reconf_restart_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clock_enable && reconf_start) |=> (state == CFG_LOADING && load_count == '0 && config_done_oe))
    else $error("valid reconfig pulse did not restart loading");
  glitch_ignored_a: assert property (@(posedge clock) disable iff (!rst_n || !clock_enable)
    (short_pulse_s ##0 (state != CFG_LOADING)) |=> state != CFG_LOADING)
    else $error("short reconfig pulse accepted");
  pullup_seen_a: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
    (!tap_in.tms_driven && tap_state == TEST_LOGIC_RESET) |=> tap_state == TEST_LOGIC_RESET)
    else $error("undriven mode select not seen as one");
  five_ones_a: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
    tms_eff [*5] |=> tap_state == TEST_LOGIC_RESET)
    else $error("five ones did not reach logic reset");
  shift_hold_a: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
    (tap_state == SHIFT_DR && !tms_eff) |=> tap_state == SHIFT_DR)
    else $error("shift state left with mode select low");
  bypass_delay_a: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
    (shift_dr && sel_by) |=> bypass == $past(tdi_eff))
    else $error("bypass path latency not one cycle");
  tdo_float_a: assert property (@(negedge test_clock) disable iff (!tap_rst_n)
    1 |=> tdo_oe == $past(shift_ir || shift_dr))
    else $error("serial output driven outside shifting");
  ir_path_a: assert property (@(negedge test_clock) disable iff (!tap_rst_n)
    shift_ir |=> tdo_out == $past(ir_so))
    else $error("serial output not from instruction path");
endmodule

// [hw/scan_chain.sv]
`timescale 1ns/1ps
module scan_chain #(
  parameter int WIDTH = 4
) (
  input wire logic tck,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] reset_value,
  input wire logic capture,
  input wire logic shift,
  input wire logic [WIDTH-1:0] capture_value,
  input wire logic si,
  output logic so,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] next_q;
  logic loaded;

  // ----------------------------------------
  // Capture or shift toward bit 0
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    if (i == WIDTH - 1) begin : g_top
      always_comb begin
        next_q[i] = capture ? capture_value[i] : (shift ? si : q[i]);
      end
    end else begin : g_mid
      always_comb begin
        next_q[i] = capture ? capture_value[i] : (shift ? q[i+1] : q[i]);
      end
    end
  end

  // Reset value is taken on the first edge after release, never from a port under reset
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      loaded <= 1'b0;
    end else begin
      q <= loaded ? next_q : reset_value;
      loaded <= 1'b1;
    end
  end

  assign so = q[0];
endmodule

// [testbench/config_test_port_tb_top.sv]
`timescale 1ns/1ps
module config_test_port_tb_top;
  import cfg_pkg::*;
  localparam logic [31:0] ID_VALUE = 32'h1234_5679; // Arbitrary value
  logic clock = 1'b0;
  logic rst_n = 1'b1;
  logic clock_enable = 1'b1;
  logic reconfig_n = 1'b1;
  logic test_clock, config_done_pin, config_done_out, config_done_oe;
  logic user_mode, config_loading, tdo_out, tdo_oe;
  tap_pins_s tap_in;
  int errors = 0;
  int cmp_count = 0;

  always #50 clock = ~clock;

  config_test_port #(.IDCODE(ID_VALUE)) dut (
    .clock(clock), .rst_n(rst_n), .clock_enable(clock_enable), .test_clock(test_clock),
    .tap_in(tap_in), .reconfig_n(reconfig_n), .config_done_pin(config_done_pin),
    .config_done_out(config_done_out), .config_done_oe(config_done_oe), .user_mode(user_mode),
    .config_loading(config_loading), .tdo_out(tdo_out), .tdo_oe(tdo_oe)
  );

  tap_host host (
    .test_clock(test_clock), .tap_in(tap_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .config_done_out(config_done_out), .config_done_oe(config_done_oe),
    .config_done_pin(config_done_pin)
  );

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits end between edges so that outputs are read settled
  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask

  // From run-idle, through one shift, back to run-idle
  task automatic xfer(input logic ir, input int n, input logic [63:0] din);
    host.nav(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    host.scan(n, din);
    host.nav(8'h01, 2);
    check("tdo_oe in shift", 64'h1, {63'h0, host.rec_oe});
    check("tdo_oe off shift", 64'h0, {63'h0, host.stray_oe});
  endtask

  task automatic pulse(input int n);
    @(posedge clock);
    reconfig_n <= 1'b0;
    repeat (n) @(posedge clock);
    reconfig_n <= 1'b1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_up();
    // A real falling edge, so that both domains take their asynchronous reset
    rst_n <= 1'b0;
    host.hold_low = 1'b1;
    cycles(8);
    @(posedge clock);
    rst_n <= 1'b1;
    cycles(60);
    check("loading early", 64'h1, {63'h0, config_loading});
    cycles(15);
    check("loading done", 64'h0, {63'h0, config_loading});
    check("done data", 64'h0, {63'h0, config_done_out});
    check("user while held", 64'h0, {63'h0, user_mode});
    host.hold_low = 1'b0;
    cycles(5);
    check("user after release", 64'h1, {63'h0, user_mode});
  endtask

  task automatic t_idcode();
    for (int i = 0; i < 6; i++) host.step(1'b0, 1'b0, 1'b1, 1'b0);
    host.nav(8'h00, 1);
    xfer(1'b0, 40, 64'h0000_00c5_0000_0000 >> 32);
    check("idcode", {24'hc5, ID_VALUE}, host.seen[39:0]);
    xfer(1'b1, 4, 64'hf);
    check("ir capture", 64'h1, host.seen[3:0]);
    xfer(1'b0, 9, 64'h0a5);
    check("bypass", 64'h14a, host.seen[8:0]);
  endtask

  task automatic t_reconfig();
    pulse(3);
    cycles(10);
    check("short pulse", 64'h1, {63'h0, user_mode});
    check("short pulse load", 64'h0, {63'h0, config_loading});
    pulse(4);
    cycles(6);
    check("reload", 64'h1, {63'h0, config_loading});
    check("user cleared", 64'h0, {63'h0, user_mode});
    xfer(1'b0, 9, 64'h03c);
    check("bypass kept", 64'h078, host.seen[8:0]);
    xfer(1'b1, 4, 64'h5);
    xfer(1'b0, 8, 64'h0);
    check("status load", 64'h01, host.seen[7:0]);
    cycles(70);
    check("reload done", 64'h1, {63'h0, user_mode});
    xfer(1'b0, 8, 64'h0);
    check("status user", 64'h02, host.seen[7:0]);
  endtask

  // Loading must stall, not finish, while the core clock enable is low
  task automatic t_freeze();
    pulse(4);
    cycles(5);
    check("freeze start", 64'h1, {63'h0, config_loading});
    @(posedge clock);
    clock_enable <= 1'b0;
    cycles(100);
    check("frozen load", 64'h1, {63'h0, config_loading});
    check("frozen user", 64'h0, {63'h0, user_mode});
    @(posedge clock);
    clock_enable <= 1'b1;
    cycles(80);
    check("thawed user", 64'h1, {63'h0, user_mode});
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    errors++;
    wrap_up();
  end

  initial begin
    t_power_up();
    t_idcode();
    t_reconfig();
    t_freeze();
    wrap_up();
  end
endmodule

// [testbench/tap_host.sv]
`timescale 1ns/1ps
module tap_host (
  output logic test_clock,
  output cfg_pkg::tap_pins_s tap_in,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic config_done_out,
  input wire logic config_done_oe,
  output logic config_done_pin
);
  import cfg_pkg::*;
  logic hold_low = 1'b0;
  logic [63:0] seen;
  logic rec_oe;
  logic stray_oe = 1'b0;
  int idx;

  // Pull-up wins unless either party sinks the wire
  assign config_done_pin = ((config_done_oe && !config_done_out) || hold_low) ? 1'b0 : 1'b1;

  initial begin
    test_clock = 1'b0;
    tap_in = '0;
  end

  // Test clock only toggles inside a step; it stands low between frames
  task automatic step(input logic tms, input logic tdi, input logic fl, input logic rec);
    tap_in.tms = fl ? ~tap_in.tms : tms;
    tap_in.tms_driven = ~fl;
    tap_in.tdi = fl ? ~tap_in.tdi : tdi;
    tap_in.tdi_driven = ~fl;
    #15;
    if (rec) begin
      seen[idx] = tdo_out;
      rec_oe = rec_oe & tdo_oe;
      idx++;
    end else begin
      stray_oe = stray_oe | tdo_oe;
    end
    test_clock = 1'b1;
    #15;
    test_clock = 1'b0;
  endtask

  task automatic nav(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'b0, 1'b0, 1'b0);
    end
  endtask

  // Last bit carries mode select high so the controller leaves the shift state
  task automatic scan(input int n, input logic [63:0] din);
    seen = '0;
    rec_oe = 1'b1;
    idx = 0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], 1'b0, 1'b1);
    end
  endtask
endmodule
